// ==== verilog/ivec_regs.svh ====
/*
 offsets, vector addresses and field positions of the vectoring unit.
 assumes: included by the package and the top module by bare name.
*/
`ifndef IVEC_REGS_SVH
`define IVEC_REGS_SVH
// fixed vector entries, low address of each 4-byte slot
`define IVEC_VEC_UND 20'hfffdc
`define IVEC_VEC_OVF 20'hfffe0
`define IVEC_VEC_BRK 20'hfffe4
`define IVEC_VEC_AMATCH 20'hfffe8
`define IVEC_VEC_SSTEP 20'hfffec
`define IVEC_VEC_WDT 20'hffff0
`define IVEC_VEC_DBC 20'hffff4
`define IVEC_VEC_NMI 20'hffff8
`define IVEC_VEC_RESET 20'hffffc
`define IVEC_VEC_HI_OFS 20'h00003
`define IVEC_BRK_ERASED 8'hff
// software number ranges
`define IVEC_SWI_UPPER_BIT 5
`define IVEC_PER_LO1 6'h05
`define IVEC_PER_HI1 6'h1f
`define IVEC_PER_LO2 6'h29
`define IVEC_PER_HI2 6'h33
// register byte offsets
`define IVEC_OFS_STATUS 12'h000
`define IVEC_STAT_U_BIT 1
`define IVEC_OFS_LASTVEC 12'h004
`define IVEC_OFS_TBASE 12'h008
`define IVEC_OFS_MEN 12'h00c
`define IVEC_MADR_PAGE 8'h01
`define IVEC_OFS_IDSEL 12'h020
`define IVEC_OFS_IDADDR 12'h024
`define IVEC_PRIO_PAGE 4'h1
`define IVEC_IDSEL_MAX 4'h8
// bus answers
`define IVEC_RESP_OKAY 2'b00
`define IVEC_RESP_SLVERR 2'b10
`endif

// ==== verilog/ivec_pkg.sv ====
/*
 types of the vectoring unit: instruction classes, sources, state.
 assumes: ivec_regs.svh on the include path.
*/
`include "ivec_regs.svh"
package ivec_pkg;
  // instruction class reported by the core at each boundary
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_ILLEGAL = 3'h1, OP_OVF_TRAP = 3'h2, OP_BRK = 3'h3,
    OP_SWI = 3'h4, OP_ARITH = 3'h5, OP_RETI = 3'h6
  } ivec_op_t;
  // source of an accepted interrupt
  typedef enum logic [3:0] {
    SRC_NONE = 4'h0, SRC_ILLEGAL = 4'h1, SRC_OVF = 4'h2, SRC_BRK = 4'h3,
    SRC_SWI = 4'h4, SRC_AMATCH = 4'h5, SRC_SSTEP = 4'h6, SRC_WDT = 4'h7,
    SRC_DBC = 4'h8, SRC_NMI = 4'h9, SRC_PERIPH = 4'ha
  } ivec_src_t;
  // whole state of the unit
  typedef struct packed {
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [19:0] tbase;
    logic [3:0] men;
    logic [3:0][19:0] madr;
    logic [3:0] idsel;
    logic [63:0][2:0] prio;
    logic ovf;
    logic usel;
    logic [3:0] ustk;
    logic [3:0] urst;
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_s3;
    logic pend_nmi;
    logic pend_wdt;
    logic pend_dbc;
    logic pend_sstep;
    logic take;
    logic [19:0] vec;
    ivec_src_t src;
    logic ack;
    logic [5:0] ack_num;
  } ivec_state_t;
endpackage

// ==== verilog/ivec_unit.sv ====
/*
 interrupt source classification and vector selection, axi4-lite regs.
 assumes: core presents one instruction boundary per exec_valid pulse and
 honours take by branching through take_vec; peripheral lines are levels.
*/
//
// How it works
// RULE_01: trap instructions ignore enable flag and levels
// RULE_02: illegal opcode vectors through lowest fixed entry
// RULE_03: overflow trap fires only with overflow set
// RULE_04: arithmetic instructions update the overflow flag
// RULE_05: breakpoint vectors through its own entry
// RULE_06: software vector takes numbers 0 to 63
// RULE_07: peripheral numbers share peripheral vectors
// RULE_08: lower numbers push, clear, restore stack select
// RULE_09: upper numbers leave stack select alone
// RULE_10: special hardware sources are never masked
// RULE_11: falling edge on nmi pin raises nmi
// RULE_12: debugger and single-step left to tools
// RULE_13: software reinitialises watchdog after its interrupt
// RULE_14: oscillator stop shares the watchdog vector
// RULE_15: enabled address match fires before instruction
// RULE_16: peripheral interrupt only on acknowledge, maskable
// RULE_17: enable flag and levels gate maskable ones
// RULE_18: four-byte vectors hold handler addresses
// RULE_19: fixed table at top, reset entry last
// RULE_20: fixed vector high bytes hold id code
// RULE_21: relocatable table is 256 bytes at base
// RULE_22: erased breakpoint high byte uses relocatable entry
`timescale 1ns/1ps
`include "ivec_regs.svh"
module ivec_unit
  import ivec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exec_valid,
  input wire ivec_op_t exec_op,
  input wire logic [5:0] exec_num,
  input wire logic exec_ovf,
  input wire logic [19:0] exec_pc,
  input wire logic i_flag,
  input wire logic [2:0] ipl,
  input wire logic [63:0] periph_req,
  input wire logic wdt_evt,
  input wire logic osc_evt,
  input wire logic dbc_evt,
  input wire logic sstep_evt,
  input wire logic nmi_pin_n,
  input wire logic [7:0] brk_vec_hi,
  output logic take,
  output logic [19:0] take_vec,
  output ivec_src_t take_src,
  output logic periph_ack,
  output logic [5:0] periph_ack_num,
  output logic stack_sel,
  output logic ovf_flag
);

  //////////////////////////////////////////////////////////////////////
  // helpers

  // numbers owned by peripheral sources
  function automatic logic is_periph(input logic [5:0] n);
    is_periph = (n >= `IVEC_PER_LO1 && n <= `IVEC_PER_HI1) ||
                (n >= `IVEC_PER_LO2 && n <= `IVEC_PER_HI2);
  endfunction

  // relocatable entry: base plus four bytes per number
  function automatic logic [19:0] reloc(input logic [19:0] b, input logic [5:0] n);
    reloc = b + {12'h000, n, 2'b00}; // [RULE_21] [RULE_18]
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  // high-byte address of fixed entry k, where the id code lives
  function automatic logic [19:0] fixed_hi(input logic [3:0] k);
    fixed_hi = `IVEC_VEC_UND + {14'h0000, k, 2'b00} + `IVEC_VEC_HI_OFS; // [RULE_20]
  endfunction

  //////////////////////////////////////////////////////////////////////
  // state

  ivec_state_t s_reg; // all flops
  ivec_state_t s_next; // next value
  logic amatch; // enabled match on this boundary
  logic hw_any; // special source pending
  logic [5:0] best_n; // best peripheral number
  logic [2:0] best_l; // its level
  logic best_v; // one is asking
  logic nmi_fall; // synced falling edge
  logic [11:0] wa; // held write address

  // peripheral arbitration: highest level, lowest number on a tie
  always_comb begin
    best_n = 6'h00;
    best_l = 3'h0;
    best_v = 1'b0;
    for (int i = 0; i < 64; i++) begin
      if (periph_req[i] && is_periph(6'(i)) && (!best_v || s_reg.prio[i] > best_l)) begin
        best_v = 1'b1;
        best_n = 6'(i);
        best_l = s_reg.prio[i];
      end
    end
  end

  // address compare against four enabled match registers
  always_comb begin
    amatch = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (s_reg.men[i] && s_reg.madr[i] == exec_pc) begin
        amatch = 1'b1; // [RULE_15]
      end
    end
  end

  assign nmi_fall = s_reg.nmi_s3 & ~s_reg.nmi_s2; // [RULE_11]
  assign hw_any = s_reg.pend_nmi | s_reg.pend_wdt | s_reg.pend_dbc | s_reg.pend_sstep;
  assign wa = s_reg.awaddr;

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic tk; // interrupt accepted now
    logic keep_u; // leave stack select as is
    s_next = s_reg;
    tk = 1'b0;
    keep_u = 1'b0;
    s_next.take = 1'b0;
    s_next.ack = 1'b0;
    // nmi pin synchroniser, third stage only for the edge
    s_next.nmi_s1 = nmi_pin_n;
    s_next.nmi_s2 = s_reg.nmi_s1;
    s_next.nmi_s3 = s_reg.nmi_s2;
    // boundary decision, specials first
    if (exec_valid) begin
      if (s_reg.pend_nmi) begin
        tk = 1'b1; // [RULE_10]
        s_next.pend_nmi = 1'b0;
        s_next.vec = `IVEC_VEC_NMI; // [RULE_11]
        s_next.src = SRC_NMI;
      end else if (s_reg.pend_wdt) begin
        tk = 1'b1; // [RULE_10]
        s_next.pend_wdt = 1'b0;
        s_next.vec = `IVEC_VEC_WDT; // [RULE_14]
        s_next.src = SRC_WDT;
      end else if (s_reg.pend_dbc) begin
        tk = 1'b1; // [RULE_10]
        s_next.pend_dbc = 1'b0;
        s_next.vec = `IVEC_VEC_DBC;
        s_next.src = SRC_DBC;
      end else if (s_reg.pend_sstep) begin
        tk = 1'b1; // [RULE_10]
        s_next.pend_sstep = 1'b0;
        s_next.vec = `IVEC_VEC_SSTEP;
        s_next.src = SRC_SSTEP;
      end else if (amatch) begin
        // taken before the instruction runs
        tk = 1'b1; // [RULE_15]
        s_next.vec = `IVEC_VEC_AMATCH;
        s_next.src = SRC_AMATCH;
      end else begin
        // trap instructions bypass i_flag and levels
        case (exec_op)
          OP_ILLEGAL: begin
            tk = 1'b1; // [RULE_01]
            s_next.vec = `IVEC_VEC_UND; // [RULE_02]
            s_next.src = SRC_ILLEGAL;
          end
          OP_OVF_TRAP: begin
            if (s_reg.ovf) begin
              tk = 1'b1; // [RULE_03] [RULE_01]
              s_next.vec = `IVEC_VEC_OVF;
              s_next.src = SRC_OVF;
            end
          end
          OP_BRK: begin
            tk = 1'b1; // [RULE_05] [RULE_01]
            s_next.src = SRC_BRK;
            if (brk_vec_hi == `IVEC_BRK_ERASED) begin
              s_next.vec = reloc(s_reg.tbase, 6'h00); // [RULE_22]
            end else begin
              s_next.vec = `IVEC_VEC_BRK;
            end
          end
          OP_SWI: begin
            tk = 1'b1; // [RULE_06] [RULE_01]
            s_next.vec = reloc(s_reg.tbase, exec_num); // [RULE_07]
            s_next.src = SRC_SWI;
            keep_u = exec_num[`IVEC_SWI_UPPER_BIT]; // [RULE_09]
          end
          OP_ARITH: begin
            s_next.ovf = exec_ovf; // [RULE_04]
          end
          OP_RETI: begin
            // pop; restore only what a push saved
            if (s_reg.urst[0]) begin
              s_next.usel = s_reg.ustk[0]; // [RULE_08]
            end
            s_next.ustk = {1'b0, s_reg.ustk[3:1]};
            s_next.urst = {1'b0, s_reg.urst[3:1]};
          end
          default: begin
          end
        endcase
        // maskable peripheral acceptance when nothing else won
        if (!tk && best_v && i_flag && best_l > ipl) begin
          tk = 1'b1; // [RULE_17]
          s_next.ack = 1'b1; // [RULE_16]
          s_next.ack_num = best_n;
          s_next.vec = reloc(s_reg.tbase, best_n);
          s_next.src = SRC_PERIPH;
        end
      end
    end
    // stack select save on acceptance, clear unless an upper software number
    if (tk) begin
      s_next.take = 1'b1;
      s_next.ustk = {s_reg.ustk[2:0], s_reg.usel};
      s_next.urst = {s_reg.urst[2:0], !keep_u};
      if (!keep_u) begin
        s_next.usel = 1'b0; // [RULE_08]
      end
    end
    // special events: set wins over the clear above
    if (nmi_fall) begin
      s_next.pend_nmi = 1'b1; // [RULE_11]
    end
    if (wdt_evt || osc_evt) begin
      s_next.pend_wdt = 1'b1; // [RULE_14]
    end
    if (dbc_evt) begin
      s_next.pend_dbc = 1'b1;
    end
    if (sstep_evt) begin
      s_next.pend_sstep = 1'b1;
    end
    // write address and data taken independently
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    // write once both halves are in
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `IVEC_RESP_OKAY;
      if (wa == `IVEC_OFS_TBASE) begin
        s_next.tbase = 20'(merge({12'h000, s_reg.tbase}, s_reg.wdata, s_reg.wstrb));
      end else if (wa == `IVEC_OFS_MEN) begin
        s_next.men = 4'(merge({28'h0, s_reg.men}, s_reg.wdata, s_reg.wstrb));
      end else if (wa[11:4] == `IVEC_MADR_PAGE) begin
        s_next.madr[wa[3:2]] =
          20'(merge({12'h000, s_reg.madr[wa[3:2]]}, s_reg.wdata, s_reg.wstrb));
      end else if (wa == `IVEC_OFS_IDSEL) begin
        s_next.idsel = 4'(merge({28'h0, s_reg.idsel}, s_reg.wdata, s_reg.wstrb));
      end else if (wa[11:8] == `IVEC_PRIO_PAGE && is_periph(wa[7:2])) begin
        s_next.prio[wa[7:2]] =
          3'(merge({29'h0, s_reg.prio[wa[7:2]]}, s_reg.wdata, s_reg.wstrb));
      end else if (wa == `IVEC_OFS_STATUS) begin
        s_next.usel = s_reg.wdata[`IVEC_STAT_U_BIT]; // software picks the stack
      end else begin
        s_next.bresp = `IVEC_RESP_SLVERR; // read-only or unmapped
      end
    end
    // response retires on bready
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    // read: data ready the cycle after the address
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `IVEC_RESP_OKAY;
      s_next.rdata = 32'h0;
      if (s_axi_araddr == `IVEC_OFS_STATUS) begin
        s_next.rdata = {20'h0, s_reg.src, s_reg.pend_nmi, s_reg.pend_wdt,
                        s_reg.pend_dbc, s_reg.pend_sstep, 2'b00, s_reg.usel, s_reg.ovf};
      end else if (s_axi_araddr == `IVEC_OFS_LASTVEC) begin
        s_next.rdata = {12'h000, s_reg.vec};
      end else if (s_axi_araddr == `IVEC_OFS_TBASE) begin
        s_next.rdata = {12'h000, s_reg.tbase};
      end else if (s_axi_araddr == `IVEC_OFS_MEN) begin
        s_next.rdata = {28'h0, s_reg.men};
      end else if (s_axi_araddr[11:4] == `IVEC_MADR_PAGE) begin
        s_next.rdata = {12'h000, s_reg.madr[s_axi_araddr[3:2]]};
      end else if (s_axi_araddr == `IVEC_OFS_IDSEL) begin
        s_next.rdata = {28'h0, s_reg.idsel};
      end else if (s_axi_araddr == `IVEC_OFS_IDADDR) begin
        if (s_reg.idsel <= `IVEC_IDSEL_MAX) begin
          s_next.rdata = {12'h000, fixed_hi(s_reg.idsel)}; // [RULE_19] [RULE_20]
        end
      end else if (s_axi_araddr[11:8] == `IVEC_PRIO_PAGE) begin
        s_next.rdata = {29'h0, s_reg.prio[s_axi_araddr[7:2]]};
      end else begin
        s_next.rresp = `IVEC_RESP_SLVERR;
      end
    end
    // readies: one write and one read in flight
    s_next.awready = !s_next.aw_held && !s_next.bvalid;
    s_next.wready = !s_next.w_held && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  // single register stage, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs straight from flops

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign take = s_reg.take;
  assign take_vec = s_reg.vec;
  assign take_src = s_reg.src;
  assign periph_ack = s_reg.ack;
  assign periph_ack_num = s_reg.ack_num;
  assign stack_sel = s_reg.usel;
  assign ovf_flag = s_reg.ovf;

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // plain boundary: no special pending, no match
  sequence plain_bnd;
    exec_valid && !hw_any && !amatch;
  endsequence

  // both write halves held
  sequence wr_ready;
    s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  endsequence

  und_vector_a: assert property ( // [RULE_02]
    plain_bnd and exec_op == OP_ILLEGAL |=> take && take_vec == `IVEC_VEC_UND)
    else $error("illegal opcode not vectored");

  ovf_gate_a: assert property ( // [RULE_03]
    plain_bnd and exec_op == OP_OVF_TRAP |=> (take && take_src == SRC_OVF) == $past(s_reg.ovf))
    else $error("overflow trap gating wrong");

  ovf_update_a: assert property ( // [RULE_04]
    plain_bnd and exec_op == OP_ARITH |=> ovf_flag == $past(exec_ovf))
    else $error("overflow flag not updated");

  brk_vector_a: assert property ( // [RULE_22]
    plain_bnd and exec_op == OP_BRK |=>
    take_vec == ($past(brk_vec_hi) == `IVEC_BRK_ERASED ? $past(s_reg.tbase) : `IVEC_VEC_BRK))
    else $error("breakpoint vector wrong");

  swi_low_a: assert property ( // [RULE_08]
    plain_bnd and exec_op == OP_SWI && !exec_num[`IVEC_SWI_UPPER_BIT] |=>
    !stack_sel && s_reg.ustk[0] == $past(stack_sel))
    else $error("stack select not saved and cleared");

  swi_high_a: assert property ( // [RULE_09]
    plain_bnd and exec_op == OP_SWI && exec_num[`IVEC_SWI_UPPER_BIT] |=>
    stack_sel == $past(stack_sel))
    else $error("stack select changed on upper number");

  nmi_edge_a: assert property ( // [RULE_11]
    $fell(s_reg.nmi_s2) |=> s_reg.pend_nmi || (take && take_src == SRC_NMI))
    else $error("nmi edge lost");

  special_first_a: assert property ( // [RULE_10]
    exec_valid && s_reg.pend_nmi |=> take && take_src == SRC_NMI && !periph_ack)
    else $error("nmi not taken at boundary");

  periph_mask_a: assert property ( // [RULE_17]
    periph_ack |-> $past(i_flag) && $past(best_l) > $past(ipl) && periph_ack_num == $past(best_n))
    else $error("peripheral accepted while masked");

  amatch_a: assert property ( // [RULE_15]
    exec_valid && amatch && !hw_any |=> take && take_vec == `IVEC_VEC_AMATCH)
    else $error("address match missed");

  wr_resp_a: assert property (
    wr_ready |=> s_axi_bvalid)
    else $error("write response not raised");

  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

endmodule

// ==== dv/ivec_core_model.sv ====
/*
 core side model: instruction boundaries, flags, event pulses, nmi pin.
 assumes: the bench calls its tasks and sets levels by hierarchy.
*/
`timescale 1ns/1ps
module ivec_core_model
  import ivec_pkg::*;
(
  input wire logic aclk,
  output logic exec_valid,
  output ivec_op_t exec_op,
  output logic [5:0] exec_num,
  output logic exec_ovf,
  output logic [19:0] exec_pc,
  output logic i_flag,
  output logic [2:0] ipl,
  output logic [63:0] periph_req,
  output logic wdt_evt,
  output logic osc_evt,
  output logic dbc_evt,
  output logic sstep_evt,
  output logic nmi_pin_n,
  output logic [7:0] brk_vec_hi
);
  ////////////////////////////////////////////////////////////////////////
  // idle levels; tool-only sources never fire
  initial begin
    exec_valid = 1'b0;
    exec_op = OP_NONE;
    exec_num = 6'h00;
    exec_ovf = 1'b0;
    exec_pc = 20'h00000;
    i_flag = 1'b0;
    ipl = 3'h0;
    periph_req = 64'h0;
    wdt_evt = 1'b0;
    osc_evt = 1'b0;
    dbc_evt = 1'b0;
    sstep_evt = 1'b0;
    nmi_pin_n = 1'b1;
    brk_vec_hi = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // one boundary pulse; released qualifiers show changed values
  task automatic step(input ivec_op_t op, input logic [5:0] num, input logic ovf,
                      input logic [19:0] pc);
    @(posedge aclk);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_num <= num;
    exec_ovf <= ovf;
    exec_pc <= pc;
    @(posedge aclk);
    exec_valid <= 1'b0;
    exec_op <= ivec_op_t'(~op);
    exec_num <= ~num;
    exec_ovf <= ~ovf;
    exec_pc <= ~pc;
  endtask
  // one watchdog or oscillator-stop pulse, one cycle wide
  task automatic pulse_evt(input logic osc);
    @(posedge aclk);
    wdt_evt <= ~osc;
    osc_evt <= osc;
    @(posedge aclk);
    wdt_evt <= 1'b0;
    osc_evt <= 1'b0;
  endtask
  // high-to-low edge on the nmi pin, held low four cycles
  task automatic nmi_fall();
    @(posedge aclk);
    nmi_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    nmi_pin_n <= 1'b1;
  endtask
endmodule

// ==== dv/ivec_unit_bench.sv ====
/*
 self-checking bench: axi4-lite register tasks and boundary tasks.
 assumes: ivec_pkg compiled first, ivec_regs.svh on the include path.
*/
`timescale 1ns/1ps
`include "ivec_regs.svh"
module ivec_unit_bench
  import ivec_pkg::*;
;
  localparam logic [19:0] BASE = 20'h12340;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic exec_valid, exec_ovf, i_flag, wdt_evt, osc_evt, dbc_evt, sstep_evt;
  logic nmi_pin_n, take, periph_ack, stack_sel, ovf_flag;
  ivec_op_t exec_op;
  ivec_src_t take_src;
  logic [5:0] exec_num, periph_ack_num;
  logic [19:0] exec_pc, take_vec;
  logic [2:0] ipl;
  logic [63:0] periph_req;
  logic [7:0] brk_vec_hi;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  int swi_nums[7] = '{0, 5, 31, 32, 41, 51, 63};
  ////////////////////////////////////////////////////////////////////////
  // core side model and the unit
  ivec_core_model core (.aclk(aclk), .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_num(exec_num), .exec_ovf(exec_ovf), .exec_pc(exec_pc), .i_flag(i_flag),
    .ipl(ipl), .periph_req(periph_req), .wdt_evt(wdt_evt), .osc_evt(osc_evt),
    .dbc_evt(dbc_evt), .sstep_evt(sstep_evt), .nmi_pin_n(nmi_pin_n),
    .brk_vec_hi(brk_vec_hi));
  ivec_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_num(exec_num), .exec_ovf(exec_ovf), .exec_pc(exec_pc), .i_flag(i_flag),
    .ipl(ipl), .periph_req(periph_req), .wdt_evt(wdt_evt), .osc_evt(osc_evt),
    .dbc_evt(dbc_evt), .sstep_evt(sstep_evt), .nmi_pin_n(nmi_pin_n),
    .brk_vec_hi(brk_vec_hi), .take(take), .take_vec(take_vec), .take_src(take_src),
    .periph_ack(periph_ack), .periph_ack_num(periph_ack_num), .stack_sel(stack_sel),
    .ovf_flag(ovf_flag));
  ////////////////////////////////////////////////////////////////////////
  // 250 mhz clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // compare, count, report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // axi4-lite write: address and data offered together, released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // axi4-lite read
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // one boundary, then the answer in the following cycle
  task automatic bnd(input ivec_op_t op, input logic [5:0] num, input logic ovf,
                     input logic [19:0] pc, input logic tk, input logic [19:0] v,
                     input ivec_src_t s);
    core.step(op, num, ovf, pc);
    @(posedge aclk);
    chk("take", {31'h0, tk}, {31'h0, take});
    if (tk) begin
      chk("take_vec", {12'h0, v}, {12'h0, take_vec});
      chk("take_src", {28'h0, s}, {28'h0, take_src});
    end
  endtask
  // verdict
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // registers: reset value, readback, read-only and unmapped places
    rd(12'h008, 32'h0, `IVEC_RESP_OKAY);
    wr(12'h008, {12'h0, BASE}, `IVEC_RESP_OKAY);
    rd(12'h008, {12'h0, BASE}, `IVEC_RESP_OKAY);
    wr(12'h004, 32'h3, `IVEC_RESP_SLVERR);
    rd(12'h800, 32'h0, `IVEC_RESP_SLVERR);
    // traps with the enable flag off
    bnd(OP_ILLEGAL, 6'h00, 1'b0, 20'h0, 1'b1, `IVEC_VEC_UND, SRC_ILLEGAL);
    bnd(OP_OVF_TRAP, 6'h00, 1'b0, 20'h0, 1'b0, 20'h0, SRC_NONE);
    bnd(OP_ARITH, 6'h00, 1'b1, 20'h0, 1'b0, 20'h0, SRC_NONE);
    chk("ovf_flag", 32'h1, {31'h0, ovf_flag});
    bnd(OP_OVF_TRAP, 6'h00, 1'b0, 20'h0, 1'b1, `IVEC_VEC_OVF, SRC_OVF);
    core.brk_vec_hi <= 8'h00;
    bnd(OP_BRK, 6'h00, 1'b0, 20'h0, 1'b1, `IVEC_VEC_BRK, SRC_BRK);
    core.brk_vec_hi <= `IVEC_BRK_ERASED;
    bnd(OP_BRK, 6'h00, 1'b0, 20'h0, 1'b1, BASE, SRC_BRK);
    // software vectors at range edges and shared peripheral numbers
    wr(12'h000, 32'h2, `IVEC_RESP_OKAY);
    foreach (swi_nums[i]) begin
      bnd(OP_SWI, 6'(swi_nums[i]), 1'b0, 20'h0, 1'b1, BASE + 20'(4 * swi_nums[i]),
          SRC_SWI);
      chk("stack_sel", 32'(swi_nums[i] > 31), {31'h0, stack_sel});
      bnd(OP_RETI, 6'h00, 1'b0, 20'h0, 1'b0, 20'h0, SRC_NONE);
      chk("stack_sel", 32'h1, {31'h0, stack_sel});
    end
    // specials: nmi wins over a pending watchdog, both taken in turn
    core.pulse_evt(1'b0);
    core.nmi_fall();
    repeat (2) @(posedge aclk);
    bnd(OP_NONE, 6'h00, 1'b0, 20'h0, 1'b1, `IVEC_VEC_NMI, SRC_NMI);
    bnd(OP_NONE, 6'h00, 1'b0, 20'h0, 1'b1, `IVEC_VEC_WDT, SRC_WDT);
    core.pulse_evt(1'b1);
    bnd(OP_NONE, 6'h00, 1'b0, 20'h0, 1'b1, `IVEC_VEC_WDT, SRC_WDT);
    // address match enabled, then disabled
    wr(12'h010, 32'h01234, `IVEC_RESP_OKAY);
    wr(12'h00c, 32'h1, `IVEC_RESP_OKAY);
    bnd(OP_NONE, 6'h00, 1'b0, 20'h01234, 1'b1, `IVEC_VEC_AMATCH, SRC_AMATCH);
    wr(12'h00c, 32'h0, `IVEC_RESP_OKAY);
    bnd(OP_NONE, 6'h00, 1'b0, 20'h01234, 1'b0, 20'h0, SRC_NONE);
    // peripheral 9 at level 3: masked, level too low, then accepted
    wr(12'h124, 32'h3, `IVEC_RESP_OKAY);
    core.periph_req[9] <= 1'b1;
    bnd(OP_NONE, 6'h00, 1'b0, 20'h0, 1'b0, 20'h0, SRC_NONE);
    core.i_flag <= 1'b1;
    core.ipl <= 3'h3;
    bnd(OP_NONE, 6'h00, 1'b0, 20'h0, 1'b0, 20'h0, SRC_NONE);
    core.ipl <= 3'h2;
    bnd(OP_NONE, 6'h00, 1'b0, 20'h0, 1'b1, BASE + 20'd36, SRC_PERIPH);
    chk("periph_ack", 32'h1, {31'h0, periph_ack});
    chk("periph_ack_num", 32'h9, {26'h0, periph_ack_num});
    core.periph_req[9] <= 1'b0;
    wr(12'h100, 32'h3, `IVEC_RESP_SLVERR);
    // fixed table: reset entry last, lowest entry first
    wr(12'h020, 32'h8, `IVEC_RESP_OKAY);
    rd(12'h024, 32'h000fffff, `IVEC_RESP_OKAY);
    wr(12'h020, 32'h0, `IVEC_RESP_OKAY);
    rd(12'h024, 32'h000fffdf, `IVEC_RESP_OKAY);
    end_sim();
  end
endmodule
